// ==== rtl/stcpcr_pkg.sv ====
package stcpcr_pkg;
    localparam int STC_W = 42;
    localparam int BASE_W = 33;
    localparam int EXT_W = 9;
    localparam int TS_W = 36;
    localparam int PID_W = 13;
    localparam logic [EXT_W-1:0] EXT_MAX = 9'h12b;
    localparam logic [BASE_W-1:0] BASE_MAX = 33'h1ffffffff;
    localparam logic [PID_W-1:0] PID_NONE = 13'h1fff;
    localparam int CLK_HZ = 100000000;
    localparam int PCR_PERIOD_MS = 100;
    localparam int TS_GAP_MS = 700;
    localparam int PCR_PERIOD_CYC = CLK_HZ / 1000 * PCR_PERIOD_MS;
    localparam logic signed [STC_W:0] SLEW_LIMIT = 43'sh40;
    // timestamp field positions: 3-bit group top, then upper and lower 15
    localparam int TS_HI_LSB = 33;
    localparam int TS_MID_LSB = 17;
    localparam int TS_LO_LSB = 1;
    localparam int TS_M0 = 32;
    localparam int TS_M1 = 16;
    localparam int TS_M2 = 0;
endpackage

// ==== rtl/stcpcr_if.sv ====
`timescale 1ns/1ps
interface stcpcr_if;
    logic pcr_valid;
    logic [32:0] pcr_base;
    logic [8:0] pcr_ext;
    logic [12:0] pcr_pid;
    logic ts_valid;
    logic has_pts;
    logic has_dts;
    logic [35:0] pts_field;
    logic [35:0] dts_field;
    modport mux (output pcr_valid, pcr_base, pcr_ext, pcr_pid, ts_valid, has_pts, has_dts,
        pts_field, dts_field);
    modport dec (input pcr_valid, pcr_base, pcr_ext, pcr_pid, ts_valid, has_pts, has_dts,
        pts_field, dts_field);
endinterface

// ==== rtl/stcpcr_mux.sv ====
`timescale 1ns/1ps
module stcpcr_mux #(
    parameter int PCR_PERIOD = stcpcr_pkg::PCR_PERIOD_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // user side
    input wire logic [12:0] pcr_pid_in,
    input wire logic au_start_in,
    input wire logic [32:0] pts_in,
    input wire logic [32:0] dts_in,
    // link
    stcpcr_if.mux link
);
    typedef struct packed {
        logic [41:0] stc;
        logic [31:0] pcr_cnt;
        logic pcr_valid;
        logic [32:0] base;
        logic [8:0] ext;
        logic ts_valid;
        logic has_dts;
        logic [35:0] pts_f;
        logic [35:0] dts_f;
    } stcpcr_mux_t;
    stcpcr_mux_t st, next_st;

    // marker bits are ones so the field cannot mimic a start code
    function automatic logic [35:0] pack_ts(input logic [32:0] v);
        pack_ts = {v[32:30], 1'b1, v[29:15], 1'b1, v[14:0], 1'b1};
    endfunction

    always_comb begin
        next_st = st;
        next_st.pcr_valid = 1'b0;
        next_st.ts_valid = 1'b0;
        if (st.stc[8:0] == stcpcr_pkg::EXT_MAX) begin
            next_st.stc[8:0] = '0;
            next_st.stc[41:9] = st.stc[41:9] + 33'h1;
        end else begin
            next_st.stc[8:0] = st.stc[8:0] + 9'h1;
        end
        if (st.pcr_cnt >= 32'(PCR_PERIOD - 1)) begin
            next_st.pcr_cnt = '0;
            next_st.pcr_valid = 1'b1;
            next_st.base = st.stc[41:9];
            next_st.ext = st.stc[8:0];
        end else begin
            next_st.pcr_cnt = st.pcr_cnt + 32'h1;
        end
        if (au_start_in) begin
            next_st.ts_valid = 1'b1;
            next_st.pts_f = pack_ts(pts_in);
            next_st.has_dts = (dts_in != pts_in);
            next_st.dts_f = pack_ts(dts_in);
        end
        if (rst_in) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    assign link.pcr_valid = st.pcr_valid;
    assign link.pcr_base = st.base;
    assign link.pcr_ext = st.ext;
    assign link.pcr_pid = pcr_pid_in;
    assign link.ts_valid = st.ts_valid;
    assign link.has_pts = st.ts_valid;
    assign link.has_dts = st.has_dts;
    assign link.pts_field = st.pts_f;
    assign link.dts_field = st.dts_f;
endmodule // stcpcr_mux

// ==== rtl/stcpcr_dec.sv ====
`timescale 1ns/1ps
module stcpcr_dec (
    input wire logic clk_in,
    input wire logic rst_in,
    // link
    stcpcr_if.dec link,
    // time and control
    output logic [41:0] stc_out,
    output logic locked_out,
    output logic signed [42:0] phase_err_out,
    output logic [1:0] freq_trim_out,
    // access unit release
    output logic decode_out,
    output logic present_out,
    output logic marker_err_out
);
    typedef struct packed {
        logic [32:0] base;
        logic [8:0] ext;
        logic locked;
        logic signed [42:0] err;
        logic [1:0] trim;
        logic pend_dec;
        logic pend_pres;
        logic [32:0] dts;
        logic [32:0] pts;
        logic dec_p;
        logic pres_p;
        logic merr;
    } stcpcr_dec_t;
    stcpcr_dec_t st, next_st;

    function automatic logic [32:0] ts_value(input logic [35:0] f);
        ts_value = {f[stcpcr_pkg::TS_HI_LSB +: 3], f[stcpcr_pkg::TS_MID_LSB +: 15],
            f[stcpcr_pkg::TS_LO_LSB +: 15]};
    endfunction

    function automatic logic ts_ok(input logic [35:0] f);
        ts_ok = f[stcpcr_pkg::TS_M0] & f[stcpcr_pkg::TS_M1] & f[stcpcr_pkg::TS_M2];
    endfunction

    // full count from base and extension
    function automatic logic [42:0] full_count(input logic [32:0] b, input logic [8:0] e);
        full_count = 43'(b) * 43'd300 + 43'(e);
    endfunction

    // modular difference, sign bit tells reached
    function automatic logic reached(input logic [32:0] now, input logic [32:0] ts);
        logic [32:0] d;
        d = now - ts;
        reached = ~d[32];
    endfunction

    logic signed [42:0] diff;

    always_comb begin
        next_st = st;
        next_st.dec_p = 1'b0;
        next_st.pres_p = 1'b0;
        next_st.merr = 1'b0;
        diff = '0;
        // one step per clock; modulo 300
        if (st.ext == stcpcr_pkg::EXT_MAX) begin
            next_st.ext = '0;
            next_st.base = st.base + 33'h1;
        end else begin
            next_st.ext = st.ext + 9'h1;
        end
        if (link.pcr_valid && link.pcr_pid != stcpcr_pkg::PID_NONE) begin
            diff = signed'(full_count(link.pcr_base, link.pcr_ext))
                - signed'(full_count(st.base, st.ext));
            next_st.err = diff;
            // large step or first reference: load phase directly
            if (!st.locked || diff > stcpcr_pkg::SLEW_LIMIT
                || diff < -stcpcr_pkg::SLEW_LIMIT) begin
                next_st.base = link.pcr_base;
                next_st.ext = link.pcr_ext;
                next_st.locked = 1'b1;
                next_st.trim = 2'h0;
            end else begin
                // small error only nudges the external oscillator
                next_st.trim = (diff > 0) ? 2'h1 : ((diff < 0) ? 2'h2 : 2'h0);
            end
        end
        if (link.pcr_valid && link.pcr_pid == stcpcr_pkg::PID_NONE) begin
            next_st.locked = 1'b0;
            next_st.trim = 2'h0;
        end
        if (st.pend_dec && reached(st.base, st.dts)) begin
            next_st.dec_p = 1'b1;
            next_st.pend_dec = 1'b0;
        end
        if (st.pend_pres && reached(st.base, st.pts)) begin
            next_st.pres_p = 1'b1;
            next_st.pend_pres = 1'b0;
        end
        // a new unit replaces any still pending one
        if (link.ts_valid && link.has_pts) begin
            next_st.merr = ~ts_ok(link.pts_field) | (link.has_dts & ~ts_ok(link.dts_field));
            next_st.pts = ts_value(link.pts_field);
            next_st.pend_pres = 1'b1;
            next_st.pend_dec = 1'b1;
            // fall back on presentation; same extractor
            next_st.dts = link.has_dts ? ts_value(link.dts_field) : ts_value(link.pts_field);
        end
        if (rst_in) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    assign stc_out = {st.base, st.ext};
    assign locked_out = st.locked;
    assign phase_err_out = st.err;
    assign freq_trim_out = st.trim;
    assign decode_out = st.dec_p;
    assign present_out = st.pres_p;
    assign marker_err_out = st.merr;
endmodule // stcpcr_dec

// ==== test/stcpcr_chk.sv ====
`timescale 1ns/1ps
module stcpcr_chk #(
    parameter int PCR_PERIOD = 50
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // link signals
    input wire logic pcr_valid,
    input wire logic [32:0] pcr_base,
    input wire logic [8:0] pcr_ext,
    input wire logic ts_valid,
    input wire logic has_pts,
    input wire logic has_dts,
    input wire logic [35:0] pts_field,
    input wire logic [35:0] dts_field
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [41:0] pcr_full;
    // full count so sample spacing is checked in count ticks, one per clock cycle
    assign pcr_full = 42'(pcr_base) * 42'd300 + 42'(pcr_ext);
    sequence next_sample_s;
        ##PCR_PERIOD pcr_valid;
    endsequence
    sequence advanced_s;
        ##PCR_PERIOD pcr_full == $past(pcr_full, PCR_PERIOD) + 42'(PCR_PERIOD);
    endsequence
    pts_markers_a: assert property (
        ts_valid |-> pts_field[32] && pts_field[16] && pts_field[0])
        else $error("presentation stamp marker low");
    dts_markers_a: assert property (
        ts_valid && has_dts |-> dts_field[32] && dts_field[16] && dts_field[0])
        else $error("decoding stamp marker low");
    pts_present_a: assert property (has_pts == ts_valid)
        else $error("stamp sent without presentation stamp");
    dts_differs_a: assert property (ts_valid && has_dts |-> dts_field != pts_field)
        else $error("decoding stamp equal to presentation stamp");
    ext_range_a: assert property (pcr_valid |-> pcr_ext <= 9'h12b)
        else $error("extension above 299");
    sample_pulse_a: assert property (pcr_valid |=> !pcr_valid)
        else $error("reference pulse longer than one cycle");
    sample_period_a: assert property (pcr_valid |-> next_sample_s)
        else $error("reference sample late");
    sample_advance_a: assert property (pcr_valid |-> advanced_s)
        else $error("reference count did not advance by the period");
endmodule // stcpcr_chk

// ==== test/tb_stc_pcr_timestamp_logic.sv ====
`timescale 1ns/1ps
module tb_stc_pcr_timestamp_logic;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [12:0] pcr_pid_in = 13'h0100;
    logic au_start_in = 1'b0;
    logic [32:0] pts_in = 33'h0;
    logic [32:0] dts_in = 33'h0;
    logic [41:0] stc_out;
    logic locked_out;
    logic decode_out;
    logic present_out;
    logic marker_err_out;
    logic signed [42:0] phase_err_out;
    logic [1:0] freq_trim_out;
    logic [31:0] lfsr = 32'd96909;
    logic [41:0] s0;
    int err_total = 0;
    int n_tests = 0;
    stcpcr_if link ();
    stcpcr_mux #(.PCR_PERIOD(50)) u_stcpcr_mux (.clk_in(clk_in), .rst_in(rst_in),
        .pcr_pid_in(pcr_pid_in), .au_start_in(au_start_in), .pts_in(pts_in),
        .dts_in(dts_in), .link(link));
    stcpcr_dec u_stcpcr_dec (.clk_in(clk_in), .rst_in(rst_in), .link(link), .stc_out(stc_out),
        .locked_out(locked_out), .phase_err_out(phase_err_out),
        .freq_trim_out(freq_trim_out), .decode_out(decode_out),
        .present_out(present_out), .marker_err_out(marker_err_out));
    stcpcr_chk #(.PCR_PERIOD(50)) u_stcpcr_chk (.clk_in(clk_in), .rst_in(rst_in),
        .pcr_valid(link.pcr_valid), .pcr_base(link.pcr_base), .pcr_ext(link.pcr_ext),
        .ts_valid(link.ts_valid), .has_pts(link.has_pts), .has_dts(link.has_dts),
        .pts_field(link.pts_field), .dts_field(link.dts_field));
    function automatic logic [31:0] next_rand(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [35:0] enc(logic [32:0] v);
        return {v[32:30], 1'b1, v[29:15], 1'b1, v[14:0], 1'b1};
    endfunction
    function automatic logic [41:0] full(logic [41:0] s);
        return 42'(s[41:9]) * 42'd300 + 42'(s[8:0]);
    endfunction
    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one access unit; base seen at each release pulse must equal its stamp
    task automatic au(logic [32:0] d, logic [32:0] p);
        logic [32:0] bd;
        logic [32:0] bp;
        logic me;
        me = 1'b0;
        bd = '1;
        bp = '1;
        pts_in = p;
        dts_in = d;
        au_start_in = 1'b1;
        tick(1);
        au_start_in = 1'b0;
        check("pts_field", link.pts_field, enc(p));
        check("has_dts", link.has_dts, d != p);
        if (d != p) check("dts_field", link.dts_field, enc(d));
        for (int i = 0; i < 1000; i++) begin
            if (decode_out === 1'b1) bd = stc_out[41:9];
            if (present_out === 1'b1) bp = stc_out[41:9];
            if (marker_err_out !== 1'b0) me = 1'b1;
            tick(1);
        end
        check("marker err", me, 1'b0);
        check("decode base", bd, d);
        check("present base", bp, p);
    endtask
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        #100us;
        err_total++;
        stop_test();
    end
    initial begin
        tick(3);
        rst_in = 1'b0;
        for (int i = 0; i < 100 && link.pcr_valid !== 1'b1; i++) tick(1);
        tick(2);
        check("locked", locked_out, 1'b1);
        s0 = stc_out;
        tick(1);
        check("stc step", full(stc_out), full(s0) + 42'd1);
        for (int i = 0; i < 400 && stc_out[8:0] !== 9'h12b; i++) tick(1);
        s0 = stc_out;
        tick(1);
        check("ext wrap", stc_out, {s0[41:9] + 33'h1, 9'h0});
        au(stc_out[41:9] + 33'h1, stc_out[41:9] + 33'h2);
        // receiver lags the sender by one count after its load, so it speeds up
        check("phase err", phase_err_out, 43'sh1);
        check("trim", freq_trim_out, 2'h1);
        au(stc_out[41:9] + 33'h2, stc_out[41:9] + 33'h2);
        repeat (2) begin
            lfsr = next_rand(lfsr);
            s0 = stc_out;
            au(s0[41:9] + 33'(lfsr[0]) + 33'h1, s0[41:9] + 33'(lfsr[0]) + 33'(lfsr[1]) + 33'h1);
        end
        pcr_pid_in = 13'h1fff;
        tick(120);
        check("no recovery", locked_out, 1'b0);
        rst_in = 1'b1;
        tick(1);
        check("reset stc", stc_out, 42'h0);
        rst_in = 1'b0;
        tick(1);
        check("stc after reset", stc_out, 42'h1);
        stop_test();
    end
endmodule // tb_stc_pcr_timestamp_logic
